// [hdl/pamux_pkg.sv]
`default_nettype none
package pamux_pkg;
   // ***************************************************************
   // pin configuration nibble codes
   // ***************************************************************
   localparam logic [3:0] CFG_ANALOG   = 4'h0;
   localparam logic [3:0] CFG_GPIO_OUT = 4'h1;
   localparam logic [3:0] CFG_GPIO_OD  = 4'h5;
   localparam logic [3:0] CFG_ALT_OUT  = 4'h9;
   localparam logic [3:0] CFG_ALT_OD   = 4'hD;
   // field positions inside the low and high config words
   localparam int A2_LSB = 8;
   localparam int A3_LSB = 12;
   localparam int A4_LSB = 0;
   localparam int A5_LSB = 4;
   localparam int A6_LSB = 8;
   // pin index in the pad vectors
   localparam int PIN_A2 = 0;
   localparam int PIN_A3 = 1;
   localparam int PIN_A4 = 2;
   localparam int PIN_A5 = 3;
   localparam int PIN_A6 = 4;
   // control bit positions and serial b mode codes
   localparam int REMAP_CH4_BIT  = 7;
   localparam int REMAP_CH2_BIT  = 5;
   localparam int SPI_MASTER_BIT = 4;
   localparam int TB_EN_CH2      = 1;
   localparam int TB_EN_CH4      = 3;
   localparam int TA_EN_CH3      = 2;
   localparam logic [1:0] SB_MODE_SPI = 2'h2;
   localparam logic [1:0] SB_MODE_I2C = 2'h3;
   // reset values and boot sampling
   localparam logic [4:0] PAD_OUT_RST  = 5'h00;
   localparam logic [4:0] PAD_OE_N_RST = 5'h1F;
   localparam logic [1:0] BOOT_SAMPLE_COUNT = 2'h2;

   typedef struct packed {
      logic [15:0] port_a_low_config;
      logic [15:0] port_a_high_config;
      logic [7:0]  timer_b_option_remap;
      logic [3:0]  timer_b_channel_enable;
      logic [3:0]  timer_a_channel_enable;
      logic [1:0]  serial_b_mode_select;
      logic [7:0]  serial_b_spi_config;
      logic        trace_enable;
      logic        trace_four_wire;
   } pamux_ctl_t;

   typedef struct packed {
      logic timer_b_channel_four;
      logic timer_b_channel_two;
      logic timer_a_channel_three;
      logic serial_b_i2c_clock;
      logic serial_b_spi_clock;
      logic core_trace_clock;
      logic core_trace_data_two;
      logic core_trace_data_three;
      logic packet_trace_frame;
      logic packet_trace_serial_data;
   } pamux_src_t;

   typedef struct packed {
      logic timer_b_channel_four;
      logic timer_b_channel_two;
      logic timer_a_channel_three;
      logic serial_b_i2c_clock;
      logic serial_b_spi_clock;
      logic serial_b_slave_select;
   } pamux_sink_t;

   function automatic logic [3:0] cfg_field(input logic [15:0] word, input int lsb);
      cfg_field = word[lsb+:4];
   endfunction : cfg_field

   function automatic logic is_alt(input logic [3:0] cfg);
      is_alt = (cfg == CFG_ALT_OUT) || (cfg == CFG_ALT_OD);
   endfunction : is_alt

   // output enable (active low) of a pin left in plain gpio use
   function automatic logic gpio_oe_n(input logic [3:0] cfg, input logic data);
      gpio_oe_n = !((cfg == CFG_GPIO_OUT) || ((cfg == CFG_GPIO_OD) && !data));
   endfunction : gpio_oe_n
endpackage : pamux_pkg
`default_nettype wire

// [hdl/pamux_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pamux_top
   (input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    input  wire pamux_pkg::pamux_ctl_t ctl_in,
    input  wire pamux_pkg::pamux_src_t src_in,
    input  wire logic [4:0]            gpio_data_in,
    input  wire logic [4:0]            pad_in,
    output var  logic [4:0]            pad_out,
    output var  logic [4:0]            pad_oe_n_out,
    output var  logic [1:0]            analog_connect_out,
    output var  logic [4:0]            gpio_read_out,
    output var  pamux_pkg::pamux_sink_t sink_out,
    output var  logic                  bootloader_request_out,
    output var  logic                  boot_sampled_out);
   import pamux_pkg::*;

   // ***************************************************************
   // pad input synchroniser
   // ***************************************************************
   logic [4:0] pad_meta;
   logic [4:0] pad_sync;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pad_meta <= 5'h00;
         pad_sync <= 5'h00;
      end else begin
         pad_meta <= pad_in;
         pad_sync <= pad_meta;
      end
   end

   // ***************************************************************
   // configuration decode
   // ***************************************************************
   wire [3:0] cfg_a2 = cfg_field(ctl_in.port_a_low_config, A2_LSB);
   wire [3:0] cfg_a3 = cfg_field(ctl_in.port_a_low_config, A3_LSB);
   wire [3:0] cfg_a4 = cfg_field(ctl_in.port_a_high_config, A4_LSB);
   wire [3:0] cfg_a5 = cfg_field(ctl_in.port_a_high_config, A5_LSB);
   wire [3:0] cfg_a6 = cfg_field(ctl_in.port_a_high_config, A6_LSB);

   wire alt_a2 = is_alt(cfg_a2);
   wire alt_a3 = is_alt(cfg_a3);
   wire alt_a4 = is_alt(cfg_a4);
   wire alt_a5 = is_alt(cfg_a5);
   wire alt_a6 = is_alt(cfg_a6);

   wire remap4 = ctl_in.timer_b_option_remap[REMAP_CH4_BIT];
   wire remap2 = ctl_in.timer_b_option_remap[REMAP_CH2_BIT];
   wire tb4_on = !remap4 && ctl_in.timer_b_channel_enable[TB_EN_CH4];
   wire tb2_on = !remap2 && ctl_in.timer_b_channel_enable[TB_EN_CH2];
   wire ta3_on = ctl_in.timer_a_channel_enable[TA_EN_CH3];

   wire sb_spi    = ctl_in.serial_b_mode_select == SB_MODE_SPI;
   wire sb_i2c    = ctl_in.serial_b_mode_select == SB_MODE_I2C;
   wire sb_master = ctl_in.serial_b_spi_config[SPI_MASTER_BIT];
   wire sb_slave  = sb_spi && !sb_master;
   wire trc_on    = ctl_in.trace_enable;
   wire trc_four  = ctl_in.trace_four_wire;

   // ***************************************************************
   // boot mode sampling
   // ***************************************************************
   // async reset cannot load a pin level, so the strap is taken once the
   // synchroniser has filled after release; pa5 stays undriven till then
   logic [1:0] boot_count;
   logic       boot_sampled;
   logic       boot_request;
   wire        boot_take = !boot_sampled && (boot_count == BOOT_SAMPLE_COUNT);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         boot_count   <= 2'h0;
         boot_sampled <= 1'b0;
         boot_request <= 1'b0;
      end else if (boot_take) begin
         boot_sampled <= 1'b1;
         boot_request <= !pad_sync[PIN_A5];
      end else if (!boot_sampled) begin
         boot_count <= boot_count + 2'h1;
      end
   end

   // ***************************************************************
   // pin selection
   // ***************************************************************
   wire a2_tim = alt_a2 && tb4_on;
   wire a2_scl = alt_a2 && !tb4_on && sb_i2c;
   wire a2_sck = alt_a2 && !tb4_on && sb_spi && sb_master;
   wire a3_tim = alt_a3 && tb2_on;
   wire a3_trc = alt_a3 && !tb2_on && trc_on;
   wire a4_ana = cfg_a4 == CFG_ANALOG;
   wire a4_pkt = alt_a4 && !trc_on;
   wire a4_trd = alt_a4 && trc_on && trc_four;
   wire a5_ana = cfg_a5 == CFG_ANALOG;
   wire a5_pkt = alt_a5 && !trc_on;
   wire a5_trd = alt_a5 && trc_on && trc_four;
   wire a6_tim = alt_a6 && ta3_on;

   logic [4:0] next_pad;
   logic [4:0] next_oe_n;

   assign next_pad[PIN_A2] = a2_tim ? src_in.timer_b_channel_four :
                             a2_sck ? src_in.serial_b_spi_clock :
                             a2_scl ? 1'b0 : gpio_data_in[PIN_A2];
   // i2c clock is open drain: drive low only, release for high
   assign next_oe_n[PIN_A2] = (a2_tim || a2_sck) ? 1'b0 :
                              a2_scl ? src_in.serial_b_i2c_clock :
                              gpio_oe_n(cfg_a2, gpio_data_in[PIN_A2]);

   assign next_pad[PIN_A3] = a3_tim ? src_in.timer_b_channel_two :
                             a3_trc ? src_in.core_trace_clock :
                             gpio_data_in[PIN_A3];
   assign next_oe_n[PIN_A3] = (a3_tim || a3_trc) ? 1'b0 :
                              gpio_oe_n(cfg_a3, gpio_data_in[PIN_A3]);

   assign next_pad[PIN_A4] = a4_pkt ? src_in.packet_trace_frame :
                             a4_trd ? src_in.core_trace_data_two :
                             gpio_data_in[PIN_A4];
   assign next_oe_n[PIN_A4] = (a4_pkt || a4_trd) ? 1'b0 :
                              gpio_oe_n(cfg_a4, gpio_data_in[PIN_A4]);

   assign next_pad[PIN_A5] = a5_pkt ? src_in.packet_trace_serial_data :
                             a5_trd ? src_in.core_trace_data_three :
                             gpio_data_in[PIN_A5];
   assign next_oe_n[PIN_A5] = !boot_sampled ? 1'b1 :
                              (a5_pkt || a5_trd) ? 1'b0 :
                              gpio_oe_n(cfg_a5, gpio_data_in[PIN_A5]);

   assign next_pad[PIN_A6] = a6_tim ? src_in.timer_a_channel_three :
                             gpio_data_in[PIN_A6];
   assign next_oe_n[PIN_A6] = a6_tim ? 1'b0 :
                              gpio_oe_n(cfg_a6, gpio_data_in[PIN_A6]);

   // ***************************************************************
   // input routing
   // ***************************************************************
   wire [4:0] ana_mask = {1'b0, a5_ana, a4_ana, 2'b00};
   pamux_sink_t next_sink;

   assign next_sink.timer_b_channel_four  = !remap4 && pad_sync[PIN_A2];
   assign next_sink.timer_b_channel_two   = !remap2 && pad_sync[PIN_A3];
   assign next_sink.timer_a_channel_three = pad_sync[PIN_A6];
   assign next_sink.serial_b_i2c_clock    = sb_i2c ? pad_sync[PIN_A2] : 1'b1;
   assign next_sink.serial_b_spi_clock    = sb_slave && pad_sync[PIN_A2];
   // slave select idles inactive (high) unless in spi slave use
   assign next_sink.serial_b_slave_select = sb_slave ? pad_sync[PIN_A3] : 1'b1;

   // ***************************************************************
   // output registers
   // ***************************************************************
   // one cycle of pin latency traded for glitch-free pad drive
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pad_out            <= PAD_OUT_RST;
         pad_oe_n_out       <= PAD_OE_N_RST;
         analog_connect_out <= 2'h0;
         gpio_read_out      <= 5'h00;
         sink_out           <= '{default: 1'b0, serial_b_i2c_clock: 1'b1,
                                 serial_b_slave_select: 1'b1};
      end else begin
         pad_out            <= next_pad;
         pad_oe_n_out       <= next_oe_n;
         analog_connect_out <= {a5_ana, a4_ana};
         gpio_read_out      <= pad_sync & ~ana_mask;
         sink_out           <= next_sink;
      end
   end

   assign bootloader_request_out = boot_request;
   assign boot_sampled_out       = boot_sampled;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_boot_wait;
      !boot_sampled;
   endsequence

   sequence s_boot_taken;
      boot_sampled && !$past(boot_sampled);
   endsequence

   chk_pa2_timer_drive: assert property (a2_tim |=> !pad_oe_n_out[PIN_A2] &&
      pad_out[PIN_A2] == $past(src_in.timer_b_channel_four))
      else $error("pa2 timer output not driven");

   chk_pa2_capture_path: assert property (!remap4 ##1 !remap4 |->
      sink_out.timer_b_channel_four == $past(pad_sync[PIN_A2]))
      else $error("pa2 capture not routed");

   chk_pa2_i2c_od: assert property (a2_scl |=> pad_out[PIN_A2] == 1'b0 &&
      pad_oe_n_out[PIN_A2] == $past(src_in.serial_b_i2c_clock))
      else $error("pa2 i2c clock not open drain");

   chk_pa2_spi_master: assert property (a2_sck |=> !pad_oe_n_out[PIN_A2] &&
      pad_out[PIN_A2] == $past(src_in.serial_b_spi_clock))
      else $error("pa2 spi clock not driven");

   chk_spi_slave_in: assert property (sb_slave |=>
      sink_out.serial_b_spi_clock == $past(pad_sync[PIN_A2]) &&
      sink_out.serial_b_slave_select == $past(pad_sync[PIN_A3]))
      else $error("spi slave inputs not routed");

   chk_pa3_trace_clk: assert property (a3_trc |=> !pad_oe_n_out[PIN_A3] &&
      pad_out[PIN_A3] == $past(src_in.core_trace_clock))
      else $error("pa3 trace clock not driven");

   chk_pa3_timer_drive: assert property (a3_tim |=> !pad_oe_n_out[PIN_A3] &&
      pad_out[PIN_A3] == $past(src_in.timer_b_channel_two))
      else $error("pa3 timer output not driven");

   chk_pa4_analog_cut: assert property (a4_ana |=> analog_connect_out[0] &&
      pad_oe_n_out[PIN_A4] && !gpio_read_out[PIN_A4])
      else $error("pa4 analog not isolated");

   chk_pa45_trace_data: assert property ((a4_trd && a5_trd && boot_sampled) |=>
      pad_out[PIN_A4] == $past(src_in.core_trace_data_two) &&
      pad_out[PIN_A5] == $past(src_in.core_trace_data_three))
      else $error("trace data not driven");

   chk_boot_window: assert property (s_boot_wait |-> ##[1:4] boot_sampled)
      else $error("boot strap never sampled");

   chk_boot_value: assert property (s_boot_taken |->
      bootloader_request_out == !$past(pad_sync[PIN_A5]))
      else $error("boot strap value wrong");

   chk_boot_release: assert property (s_boot_wait |=> pad_oe_n_out[PIN_A5])
      else $error("pa5 driven before strap sample");

   chk_pa6_timer: assert property (a6_tim |=> !pad_oe_n_out[PIN_A6] &&
      pad_out[PIN_A6] == $past(src_in.timer_a_channel_three))
      else $error("pa6 timer output not driven");

   chk_pa6_capture: assert property (1'b1 |=>
      sink_out.timer_a_channel_three == $past(pad_sync[PIN_A6]))
      else $error("pa6 capture not routed");

   chk_gpio_plain: assert property ((cfg_a6 == CFG_GPIO_OUT) |=>
      !pad_oe_n_out[PIN_A6] && pad_out[PIN_A6] == $past(gpio_data_in[PIN_A6]))
      else $error("pa6 gpio output wrong");

   // capture paths must read quiet while the channel is remapped away
   chk_pa2_capture_off: assert property (remap4 |=> !sink_out.timer_b_channel_four)
      else $error("pa2 capture leaks while remapped");

   chk_pa3_capture_path: assert property (!remap2 ##1 !remap2 |->
      sink_out.timer_b_channel_two == $past(pad_sync[PIN_A3]))
      else $error("pa3 capture not routed");

   chk_pa3_capture_off: assert property (remap2 |=> !sink_out.timer_b_channel_two)
      else $error("pa3 capture leaks while remapped");

   chk_pkt_trace_out: assert property ((a4_pkt && a5_pkt) |=>
      !pad_oe_n_out[PIN_A4] && pad_out[PIN_A4] == $past(src_in.packet_trace_frame) &&
      pad_out[PIN_A5] == $past(src_in.packet_trace_serial_data))
      else $error("packet trace not driven");

   chk_pa5_analog_cut: assert property (a5_ana |=> analog_connect_out[1] &&
      pad_oe_n_out[PIN_A5] && !gpio_read_out[PIN_A5])
      else $error("pa5 analog not isolated");

   chk_slave_idle_in: assert property (!sb_slave |=>
      !sink_out.serial_b_spi_clock && sink_out.serial_b_slave_select)
      else $error("spi slave inputs not idle");

   chk_trace_two_wire: assert property ((alt_a4 && trc_on && !trc_four) |=>
      pad_oe_n_out[PIN_A4])
      else $error("pa4 driven without four-wire trace");

   chk_pa6_released: assert property ((!alt_a6 && cfg_a6 != CFG_GPIO_OUT &&
      cfg_a6 != CFG_GPIO_OD) |=> pad_oe_n_out[PIN_A6])
      else $error("pa6 driven while unselected");
endmodule : pamux_top
`default_nettype wire

// [tb/pamux_board.sv]
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// board side of the five pads: pull-ups plus optional external drivers
// ***************************************************************
module pamux_board
   (input  wire logic [4:0] dev_data_in,
    input  wire logic [4:0] dev_oe_n_in,
    input  wire logic [4:0] ext_en_in,
    input  wire logic [4:0] ext_val_in,
    output logic      [4:0] pad_level_out);
   // device wins a clash; a pad nobody drives floats to its pull-up
   // the strap level on pa5 is held through ext_en_in/ext_val_in
   assign pad_level_out = (~dev_oe_n_in & dev_data_in)
                        | (dev_oe_n_in & ext_en_in & ext_val_in)
                        | (dev_oe_n_in & ~ext_en_in);
endmodule : pamux_board
`default_nettype wire

// [tb/pamux_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pamux_top_tb;
   import pamux_pkg::*;
   // ***************************************************************
   // stimulus, device and board
   // ***************************************************************
   logic        clk_in;
   logic        rstn_in;
   pamux_ctl_t  ctl;
   pamux_src_t  src;
   pamux_sink_t sink_out;
   logic [4:0]  gpio_data, pad_in, pad_out, pad_oe_n_out, gpio_read_out, ext_en, ext_val;
   logic [1:0]  analog_connect_out;
   logic        bootloader_request_out, boot_sampled_out;
   int          n_mismatch, num_checks, cycles;

   pamux_top uut (.clk_in(clk_in), .rstn_in(rstn_in), .ctl_in(ctl), .src_in(src),
      .gpio_data_in(gpio_data), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe_n_out(pad_oe_n_out), .analog_connect_out(analog_connect_out),
      .gpio_read_out(gpio_read_out), .sink_out(sink_out),
      .bootloader_request_out(bootloader_request_out),
      .boot_sampled_out(boot_sampled_out));
   pamux_board board (.dev_data_in(pad_out), .dev_oe_n_in(pad_oe_n_out),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pad_in));

   initial begin
      clk_in = 1'h0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // pad path is one edge out plus two sync stages plus one register
   task automatic settle();
      repeat (5) @(posedge clk_in);
      #5;
   endtask : settle

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         final_report();
      end
   end

   // ***************************************************************
   // test sequence
   // ***************************************************************
   initial begin
      rstn_in = 1'h0;
      ctl = '0;
      src = '0;
      gpio_data = 5'h00;
      ext_en = 5'h08;
      ext_val = 5'h00;
      ctl.port_a_low_config = 16'h4400;
      // pa5 set to drive, so the hold-off before the strap sample shows
      ctl.port_a_high_config = 16'h0414;
      repeat (8) @(posedge clk_in);
      #5;
      chk("reset oe_n", 5'h1F, pad_oe_n_out);
      chk("reset out", 5'h00, pad_out);
      rstn_in = 1'h1;
      repeat (2) @(posedge clk_in);
      #5;
      chk("pa5 oe_n pre strap", 1'h1, pad_oe_n_out[PIN_A5]);
      settle();
      chk("pa5 oe_n post strap", 1'h0, pad_oe_n_out[PIN_A5]);
      chk("boot sampled", 1'h1, boot_sampled_out);
      chk("boot request", 1'h1, bootloader_request_out);
      ctl.port_a_high_config[7:4] = 4'h4;
      ext_en = 5'h00;
      ctl.port_a_low_config[11:8] = CFG_ALT_OUT;
      ctl.timer_b_channel_enable[TB_EN_CH4] = 1'h1;
      for (int v = 0; v < 2; v++) begin
         src.timer_b_channel_four = v[0];
         settle();
         chk("pa2 oe_n", 1'h0, pad_oe_n_out[PIN_A2]);
         chk("pa2 timer", v[0], pad_out[PIN_A2]);
         chk("ch4 capture", v[0], sink_out.timer_b_channel_four);
      end
      ctl.serial_b_mode_select = SB_MODE_SPI;
      ctl.serial_b_spi_config[SPI_MASTER_BIT] = 1'h1;
      ctl.timer_b_option_remap[REMAP_CH4_BIT] = 1'h1;
      src.serial_b_spi_clock = 1'h1;
      settle();
      chk("pa2 spi clock", 1'h1, pad_out[PIN_A2]);
      chk("ch4 remapped", 1'h0, sink_out.timer_b_channel_four);
      ctl.serial_b_mode_select = SB_MODE_I2C;
      ctl.port_a_low_config[11:8] = CFG_ALT_OD;
      for (int v = 0; v < 2; v++) begin
         src.serial_b_i2c_clock = v[0];
         settle();
         chk("i2c oe_n", v[0], pad_oe_n_out[PIN_A2]);
         chk("i2c out", 1'h0, pad_out[PIN_A2]);
         chk("i2c in", v[0], sink_out.serial_b_i2c_clock);
      end
      ctl.serial_b_mode_select = SB_MODE_SPI;
      ctl.serial_b_spi_config[SPI_MASTER_BIT] = 1'h0;
      ctl.port_a_low_config = 16'h4400;
      ext_en = 5'h03;
      for (int v = 0; v < 2; v++) begin
         ext_val = {3'h0, ~v[0], v[0]};
         settle();
         chk("slave clock", v[0], sink_out.serial_b_spi_clock);
         chk("slave select", !v[0], sink_out.serial_b_slave_select);
      end
      ext_en = 5'h00;
      ctl.port_a_low_config[15:12] = CFG_ALT_OUT;
      ctl.timer_b_channel_enable[TB_EN_CH2] = 1'h1;
      for (int v = 0; v < 2; v++) begin
         src.timer_b_channel_two = v[0];
         settle();
         chk("pa3 timer", v[0], pad_out[PIN_A3]);
         chk("ch2 capture", v[0], sink_out.timer_b_channel_two);
      end
      ctl.trace_enable = 1'h1;
      ctl.timer_b_option_remap[REMAP_CH2_BIT] = 1'h1;
      src.core_trace_clock = 1'h1;
      settle();
      chk("pa3 trace clock", 1'h1, pad_out[PIN_A3]);
      chk("ch2 remapped", 1'h0, sink_out.timer_b_channel_two);
      ctl.port_a_high_config[7:0] = 8'h00;
      settle();
      chk("analog connect", 2'h3, analog_connect_out);
      chk("analog oe_n", 2'h3, pad_oe_n_out[PIN_A5:PIN_A4]);
      chk("analog read", 2'h0, gpio_read_out[PIN_A5:PIN_A4]);
      ctl.port_a_high_config[7:0] = 8'h99;
      for (int v = 0; v < 4; v++) begin
         ctl.trace_enable = v[1];
         ctl.trace_four_wire = v[1];
         src.packet_trace_frame = v[0];
         src.packet_trace_serial_data = ~v[0];
         src.core_trace_data_two = ~v[0];
         src.core_trace_data_three = v[0];
         settle();
         chk("analog off", 2'h0, analog_connect_out);
         if (v < 2) begin
            chk("packet frame", v[0], pad_out[PIN_A4]);
            chk("packet data", !v[0], pad_out[PIN_A5]);
         end else begin
            chk("trace data two", !v[0], pad_out[PIN_A4]);
            chk("trace data three", v[0], pad_out[PIN_A5]);
         end
      end
      ctl.trace_four_wire = 1'h0;
      settle();
      chk("two wire oe_n", 2'h3, pad_oe_n_out[PIN_A5:PIN_A4]);
      ctl.port_a_high_config[11:8] = CFG_ALT_OUT;
      ctl.timer_a_channel_enable[TA_EN_CH3] = 1'h1;
      for (int v = 0; v < 2; v++) begin
         src.timer_a_channel_three = v[0];
         settle();
         chk("pa6 timer", v[0], pad_out[PIN_A6]);
         chk("ch3 capture", v[0], sink_out.timer_a_channel_three);
      end
      ctl.port_a_high_config[11:8] = 4'h4;
      ext_en = 5'h10;
      ext_val = 5'h00;
      settle();
      chk("pa6 released", 1'h1, pad_oe_n_out[PIN_A6]);
      chk("ch3 capture in", 1'h0, sink_out.timer_a_channel_three);
      ext_en = 5'h00;
      ctl.port_a_low_config = 16'h1100;
      ctl.port_a_high_config[11:8] = CFG_GPIO_OUT;
      gpio_data = 5'h11;
      settle();
      chk("gpio out", 2'h1, pad_out[PIN_A3:PIN_A2]);
      chk("gpio oe_n", 2'h0, pad_oe_n_out[PIN_A3:PIN_A2]);
      chk("gpio read", 2'h1, gpio_read_out[PIN_A3:PIN_A2]);
      chk("pa6 gpio out", 1'h1, pad_out[PIN_A6]);
      chk("pa6 gpio oe_n", 1'h0, pad_oe_n_out[PIN_A6]);
      // second reset with the strap held high: no bootloader request
      rstn_in = 1'h0;
      ext_en = 5'h08;
      ext_val = 5'h08;
      repeat (2) @(posedge clk_in);
      #5;
      chk("boot cleared", 1'h0, boot_sampled_out);
      rstn_in = 1'h1;
      settle();
      chk("boot sampled again", 1'h1, boot_sampled_out);
      chk("no boot request", 1'h0, bootloader_request_out);
      final_report();
   end
endmodule : pamux_top_tb
`default_nettype wire
